// ---- design/fecw_fifo.sv ----
// Purpose: parameterised first-in first-out buffer with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: ready and valid come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module fecw_fifo #(
  parameter int W = 6, // word width
  parameter int DEPTH = 4 // entries
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word to write
  output logic out_valid, // a word is held
  input wire logic out_ready, // read request
  output logic [W-1:0] out_data // oldest word
);
  import fecw_pkg::*;

  localparam int AW = $clog2(DEPTH); // pointer width
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH); // fill level when full

  // whole state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // storage
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // fill level
    logic nf; // not full
    logic ne; // not empty
  } fecw_fifo_st_t;

  fecw_fifo_st_t s_q; // registered state
  fecw_fifo_st_t s_d; // next state
  logic push; // accepted write
  logic pop; // accepted read

  ///////////////////////////////////////////////////////////////////////////
  // next state: whole words only, reads of an empty buffer do nothing
  always_comb begin
    s_d = s_q;
    push = in_valid && s_q.nf;
    pop = out_ready && s_q.ne;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    s_d.nf = (s_d.cnt != FULL_CNT);
    s_d.ne = (s_d.cnt != '0);
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.nf <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.nf;
  assign out_valid = s_q.ne;
  assign out_data = s_q.mem[s_q.rp];

  ///////////////////////////////////////////////////////////////////////////
  // checks
  a_empty_read_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (out_ready && !s_q.ne && !in_valid) |=> ($stable(s_q.rp) && (s_q.cnt == '0)))
    else $error("read of empty fifo moved state");
  a_fill_bound: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.cnt <= FULL_CNT) && (s_q.ne == (s_q.cnt != '0)))
    else $error("fifo fill level or empty flag wrong");
endmodule
`default_nettype wire

// ---- design/fecw_pkg.sv ----
// Purpose: shared constants, types and helpers of the far-end alarm codeword controller
// Assumes: one clock; line bits arrive as strobes synchronous to clk
// Notes: code registers keep the first serial bit in bit 0
//
// Summary of operation
// - code bits travel first-to-last on the line
// - first serial bit in register bit 0
// - two writable transmit codes, first and second
// - four modes; idle sends all ones
// - single mode: first code ten times, then ones
// - dual mode: first ten, second ten, ones
// - continuous mode repeats first code until changed
// - codeword is 0, code, 0, eight ones
// - receiver checks every bit position for framing
// - three equal codewords set detect, push code
// - two differing codewords or idle clear detect
// - sixteen consecutive ones declare idle
// - idle ends when detect becomes set
// - code fifo holds four whole six-bit codes
// - code fifo reports empty status
// - code arriving while full discarded, overflow flagged
// - read of empty fifo is ignored
// - line processing and reads act independently
package fecw_pkg;

  localparam int CODE_W = 6; // bits in one alarm code
  localparam int CW_LEN = 16; // bits in one codeword
  localparam logic [3:0] REP_COUNT = 4'h0a; // codewords per code in single and dual mode
  localparam logic [1:0] DET_REPEATS = 2'h3; // equal codewords needed for detection
  localparam logic [1:0] DIFF_LIMIT = 2'h2; // differing codewords that drop detection
  localparam logic [4:0] IDLE_ONES = 5'h10; // consecutive ones that declare idle
  localparam logic [4:0] SLOT_LIMIT = 5'h10; // bits without framing that break a run
  localparam int CODE_FIFO_DEPTH = 4; // receive code fifo entries
  localparam int BIT_FIFO_DEPTH = 16; // line bit buffer entries
  localparam logic [7:0] CW_TAIL = 8'hff; // trailing ones of a codeword
  localparam logic [15:0] ALL_ONES = 16'hffff; // idle line word

  // transmit mode select
  typedef enum logic [1:0] {
    FECW_MODE_IDLE,
    FECW_MODE_SINGLE,
    FECW_MODE_DUAL,
    FECW_MODE_CONT
  } fecw_mode_t;

  // code write strobes with their data
  typedef struct packed {
    logic wr_first; // load tx_code_first
    logic wr_second; // load tx_code_second
    logic [CODE_W-1:0] code; // code, first serial bit in bit 0
  } fecw_code_wr_t;

  // receive status bits
  typedef struct packed {
    logic detected; // code detection indication
    logic idle; // idle condition
    logic empty; // code fifo empty
    logic overflow; // sticky code fifo overflow
  } fecw_rx_stat_t;

  // builds the 16-bit codeword, first bit to send in bit 15
  function automatic logic [15:0] fecw_build_cw(input logic [CODE_W-1:0] code);
    logic [15:0] w;
    w = {1'b0, 6'h00, 1'b0, CW_TAIL};
    for (int i = 0; i < CODE_W; i++) begin
      w[14-i] = code[i];
    end
    return w;
  endfunction

  // true when the last 16 line bits (oldest in bit 15) form a codeword
  function automatic logic fecw_is_frame(input logic [15:0] h);
    return (h[15] == 1'b0) && (h[8] == 1'b0) && (h[7:0] == CW_TAIL);
  endfunction

  // pulls the code out of a framed window, first received bit into bit 0
  function automatic logic [CODE_W-1:0] fecw_get_code(input logic [15:0] h);
    logic [CODE_W-1:0] c;
    c = '0;
    for (int i = 0; i < CODE_W; i++) begin
      c[i] = h[14-i];
    end
    return c;
  endfunction

endpackage

// ---- design/fecw_top.sv ----
// Purpose: far-end alarm codeword transmit serialiser, receive detector and code fifo
// Assumes: one line bit per tx_bit_req strobe; rx bits offered with valid/ready
// Notes: all outputs are registered; line bits pass a 16-deep buffer first
`timescale 1ns/1ps
`default_nettype none
module fecw_top (
  input wire logic clk, // system clock, 20 MHz
  input wire logic sys_rst, // async reset, active high
  input wire fecw_pkg::fecw_code_wr_t code_wr, // transmit code writes
  input wire fecw_pkg::fecw_mode_t tx_mode, // mode to select
  input wire logic tx_mode_wr, // one-cycle mode write strobe
  input wire logic tx_bit_req, // line asks for next transmit bit
  output logic tx_bit_out, // transmit codeword stream bit
  output logic [5:0] tx_code_first, // readback of first code
  output logic [5:0] tx_code_second, // readback of second code
  input wire logic rx_bit_valid, // received line bit offered
  input wire logic rx_bit, // received line bit
  output logic rx_bit_ready, // line bit buffer has room
  input wire logic rx_code_rd, // one-cycle read of code fifo
  input wire logic rx_ovf_clr, // one-cycle clear of overflow flag
  output logic [5:0] rx_code_fifo_out, // last code read from fifo
  output fecw_pkg::fecw_rx_stat_t rx_stat // receive status
);
  import fecw_pkg::*;

  // transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_A,
    TX_B,
    TX_CONT
  } fecw_tx_st_t;

  // whole state of the block
  typedef struct packed {
    logic [5:0] code_a; // first transmit code
    logic [5:0] code_b; // second transmit code
    fecw_mode_t mode; // selected mode
    logic restart; // mode written, take at next boundary
    fecw_tx_st_t st; // transmit sequencer
    logic [3:0] rep; // codewords sent of current code
    logic [3:0] bcnt; // bits left in current word
    logic [15:0] sh; // transmit shift register
    logic out; // transmit bit
    logic [15:0] hist; // last 16 received bits, newest in bit 0
    logic [4:0] ones; // consecutive received ones
    logic [4:0] since; // bits since last framing match
    logic [5:0] cand; // candidate code
    logic [1:0] cnt; // consecutive matches of candidate
    logic [5:0] det_code; // currently detected code
    logic det; // detection indication
    logic [1:0] diff; // consecutive codewords differing from detected
    logic idle; // idle condition
    logic push; // code pushed into fifo this cycle
    logic ovf; // sticky overflow
    logic empty; // registered empty flag
    logic [5:0] rd_code; // code read out
  } fecw_st_t;

  fecw_st_t s_q; // registered state
  fecw_st_t s_d; // next state

  logic buf_valid; // line bit buffer has a bit
  logic buf_bit; // oldest buffered bit
  logic take; // processor consumes a bit this cycle
  logic code_ready; // code fifo has room
  logic code_valid; // code fifo holds a code
  logic [5:0] code_head; // oldest code in fifo

  ///////////////////////////////////////////////////////////////////////////
  // line bit buffer; the detector stalls it for one cycle per pushed code
  fecw_fifo #(
    .W(1),
    .DEPTH(BIT_FIFO_DEPTH)
  ) u_bit_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(rx_bit_valid),
    .in_ready(rx_bit_ready),
    .in_data(rx_bit),
    .out_valid(buf_valid),
    .out_ready(take),
    .out_data(buf_bit)
  );

  // receive code fifo, written by the line side, read by software
  fecw_fifo #(
    .W(CODE_W),
    .DEPTH(CODE_FIFO_DEPTH)
  ) u_code_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(s_q.push),
    .in_ready(code_ready),
    .in_data(s_q.det_code),
    .out_valid(code_valid),
    .out_ready(rx_code_rd),
    .out_data(code_head)
  );

  assign take = buf_valid && !s_q.push;

  ///////////////////////////////////////////////////////////////////////////
  // next state for transmit, receive and fifo status
  always_comb begin
    fecw_tx_st_t st;
    logic [3:0] rep;
    logic [15:0] word;
    logic [15:0] h;
    logic [5:0] c;
    st = s_q.st;
    rep = s_q.rep;
    word = ALL_ONES;
    h = s_q.hist;
    c = '0;
    s_d = s_q;
    s_d.push = 1'b0;

    // code storage writes
    if (code_wr.wr_first) begin
      s_d.code_a = code_wr.code;
    end
    if (code_wr.wr_second) begin
      s_d.code_b = code_wr.code;
    end
    // a mode write is held until the current word ends
    if (tx_mode_wr) begin
      s_d.mode = tx_mode;
      s_d.restart = 1'b1;
    end

    // transmit: one bit per line request
    if (tx_bit_req) begin
      if (s_q.bcnt == '0) begin
        // word boundary: pick the next word
        if (s_q.restart) begin
          rep = '0;
          // a mode write that lands on this very edge stays pending for the next word
          s_d.restart = tx_mode_wr;
          case (s_q.mode)
            FECW_MODE_IDLE: begin
              st = TX_IDLE;
            end
            FECW_MODE_CONT: begin
              st = TX_CONT;
            end
            default: begin
              st = TX_A;
            end
          endcase
        end
        case (st)
          TX_A: begin
            word = fecw_build_cw(s_q.code_a);
            rep = rep + 1'b1;
            if (rep == REP_COUNT) begin
              rep = '0;
              st = (s_q.mode == FECW_MODE_DUAL) ? TX_B : TX_IDLE;
            end
          end
          TX_B: begin
            word = fecw_build_cw(s_q.code_b);
            rep = rep + 1'b1;
            if (rep == REP_COUNT) begin
              rep = '0;
              st = TX_IDLE;
            end
          end
          TX_CONT: begin
            word = fecw_build_cw(s_q.code_a);
          end
          default: begin
            word = ALL_ONES;
            st = TX_IDLE;
          end
        endcase
        s_d.st = st;
        s_d.rep = rep;
        s_d.out = word[15];
        s_d.sh = {word[14:0], 1'b1};
        s_d.bcnt = 4'(CW_LEN - 1);
      end else begin
        // inside a word: shift out the next bit
        s_d.out = s_q.sh[15];
        s_d.sh = {s_q.sh[14:0], 1'b1};
        s_d.bcnt = s_q.bcnt - 1'b1;
      end
    end

    // receive: every bit position is a framing candidate
    if (take) begin
      h = {s_q.hist[14:0], buf_bit};
      s_d.hist = h;
      // idle detection on a run of ones
      if (buf_bit) begin
        s_d.ones = (s_q.ones == IDLE_ONES) ? IDLE_ONES : s_q.ones + 1'b1;
      end else begin
        s_d.ones = '0;
      end
      if ((s_d.ones == IDLE_ONES) && (s_q.ones != IDLE_ONES)) begin
        s_d.idle = 1'b1;
        s_d.det = 1'b0;
        s_d.diff = '0;
      end
      // a codeword must follow within one codeword length
      s_d.since = (s_q.since == SLOT_LIMIT) ? SLOT_LIMIT : s_q.since + 1'b1;
      if (s_d.since == SLOT_LIMIT) begin
        s_d.cnt = '0;
      end
      if (fecw_is_frame(h)) begin
        c = fecw_get_code(h);
        s_d.since = '0;
        // losing the detected code
        if (s_q.det && (c != s_q.det_code)) begin
          s_d.diff = s_q.diff + 1'b1;
          if (s_d.diff == DIFF_LIMIT) begin
            s_d.det = 1'b0;
            s_d.diff = '0;
          end
        end else begin
          s_d.diff = '0;
        end
        // counting equal codewords
        if ((s_q.cnt != '0) && (c == s_q.cand)) begin
          s_d.cnt = (s_q.cnt == DET_REPEATS) ? DET_REPEATS : s_q.cnt + 1'b1;
        end else begin
          s_d.cand = c;
          s_d.cnt = 2'h1;
        end
        if ((s_d.cnt == DET_REPEATS) && (s_q.cnt != DET_REPEATS)) begin
          s_d.det = 1'b1;
          s_d.det_code = c;
          s_d.push = 1'b1;
          s_d.diff = '0;
          s_d.idle = 1'b0;
        end
      end
    end

    // overflow: a set in the same cycle as a clear wins, so a lost code is never hidden
    if (rx_ovf_clr) begin
      s_d.ovf = 1'b0;
    end
    if (s_q.push && !code_ready) begin
      s_d.ovf = 1'b1;
    end
    // software read of the fifo; empty reads leave the data alone
    if (rx_code_rd && code_valid) begin
      s_d.rd_code = code_head;
    end
    s_d.empty = !code_valid;
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.out <= 1'b1;
      s_q.sh <= ALL_ONES;
      s_q.hist <= ALL_ONES;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign tx_bit_out = s_q.out;
  assign tx_code_first = s_q.code_a;
  assign tx_code_second = s_q.code_b;
  assign rx_code_fifo_out = s_q.rd_code;
  assign rx_stat = '{detected: s_q.det, idle: s_q.idle, empty: s_q.empty, overflow: s_q.ovf};

  ///////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_idle_sends_ones: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && !s_q.restart && (s_q.st == TX_IDLE)) |=> tx_bit_out)
    else $error("idle mode did not send a one");
  // once the lead bit is out, the shifter holds the rest of the word one place up
  a_cw_lead_zero: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && !s_q.restart && (s_q.st == TX_CONT))
    |=> (!tx_bit_out && (s_q.sh[9] == 1'b0) && (s_q.sh[8:1] == CW_TAIL)))
    else $error("codeword framing wrong");
  a_rep_bound: assert property (
    (s_q.rep < REP_COUNT) && !((s_q.st == TX_IDLE) && (s_q.rep != '0)))
    else $error("repeat counter out of range");
  a_dual_to_second: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && !s_q.restart && (s_q.st == TX_A)
     && (s_q.rep == REP_COUNT - 1'b1) && (s_q.mode == FECW_MODE_DUAL)) |=> (s_q.st == TX_B))
    else $error("dual mode did not move to second code");
  a_detect_pushes: assert property (
    $rose(s_q.det) |-> (s_q.push && (s_q.det_code == s_q.cand) && (s_q.cnt == DET_REPEATS)))
    else $error("detection without push of the code");
  a_idle_on_ones: assert property (
    (take && buf_bit && (s_q.ones == IDLE_ONES - 1'b1)) |=> (s_q.idle && !s_q.det))
    else $error("sixteen ones did not declare idle");
  a_detect_ends_idle: assert property (
    $rose(s_q.det) |-> !s_q.idle)
    else $error("idle survived detection");
  a_overflow_flag: assert property (
    (s_q.push && !code_ready) |=> s_q.ovf)
    else $error("full fifo push did not flag overflow");
  a_empty_status: assert property (
    ##1 (rx_stat.empty == !$past(code_valid)))
    else $error("empty status disagrees with fifo");

  // transmit sequencing at word boundaries
  a_single_to_idle: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && !s_q.restart && (s_q.st == TX_A)
     && (s_q.rep == REP_COUNT - 1'b1) && (s_q.mode == FECW_MODE_SINGLE))
    |=> (s_q.st == TX_IDLE))
    else $error("single mode did not fall back to ones");
  a_second_to_idle: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && !s_q.restart && (s_q.st == TX_B)
     && (s_q.rep == REP_COUNT - 1'b1)) |=> (s_q.st == TX_IDLE))
    else $error("dual mode did not fall back to ones");
  a_cont_repeats: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && !s_q.restart && (s_q.st == TX_CONT))
    |=> (s_q.st == TX_CONT))
    else $error("continuous mode stopped by itself");
  a_word_length: assert property (
    (tx_bit_req && (s_q.bcnt == '0)) |=> (s_q.bcnt == 4'(CW_LEN - 1)))
    else $error("codeword length counter not loaded");
  a_mode_restart: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && s_q.restart && (s_q.mode == FECW_MODE_IDLE))
    |=> ((s_q.st == TX_IDLE) && (s_q.rep == '0) && tx_bit_out))
    else $error("mode write did not restart at the boundary");
  a_restart_counts: assert property (
    (tx_bit_req && (s_q.bcnt == '0) && s_q.restart
     && ((s_q.mode == FECW_MODE_SINGLE) || (s_q.mode == FECW_MODE_DUAL)))
    |=> ((s_q.st == TX_A) && (s_q.rep == 4'h1) && !tx_bit_out))
    else $error("new mode did not count from zero");

  // receive status and fifo read side
  a_ovf_sticky: assert property (
    (s_q.ovf && !rx_ovf_clr) |=> s_q.ovf)
    else $error("overflow flag dropped without a clear");
  a_empty_read_keeps: assert property (
    (rx_code_rd && !code_valid) |=> $stable(rx_code_fifo_out))
    else $error("read of empty fifo changed the code output");
endmodule
`default_nettype wire

// ---- dv/fecw_line_model.sv ----
// Purpose: line-side partner of the alarm codeword block
// Assumes: it drives at falling edges and the block samples at rising edges
// Notes: a released receive line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module fecw_line_model (
  input wire logic clk, // system clock
  output logic tx_bit_req, // asks for the next transmit bit
  input wire logic tx_bit_out, // transmit bit from the block
  output logic rx_bit_valid, // received bit offered
  output logic rx_bit, // received bit
  input wire logic rx_bit_ready, // block buffer has room
  output logic fault // a bounded wait ran out
);
  // idle levels at time zero
  initial begin
    tx_bit_req = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b1;
    fault = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulls one 16-bit word, first line bit into bit 15
  task automatic get_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk) tx_bit_req = 1'b1;
      @(negedge clk) tx_bit_req = 1'b0;
      @(negedge clk);
      w[i] = tx_bit_out;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // offers one 16-bit word, bit 15 first, holding each bit until taken
  task automatic send_word(input logic [15:0] w);
    int k;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      rx_bit_valid = 1'b1;
      rx_bit = w[i];
      k = 0;
      // ready is registered, so its level at the falling edge holds to the next rise
      while (rx_bit_ready !== 1'b1 && k < 64) begin
        @(negedge clk);
        k++;
      end
      if (k == 64) begin
        fault = 1'b1;
      end
    end
    @(negedge clk);
    rx_bit_valid = 1'b0;
    rx_bit = ~w[0]; // released line must not look held
  endtask
endmodule
`default_nettype wire

// ---- dv/test_fecw_top.sv ----
// Purpose: self-checking bench of the alarm codeword controller
// Assumes: inputs change at falling edges; the partner plays the line
// Notes: expected words are built here from the codeword framing
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module test_fecw_top;
  import fecw_pkg::*;
  localparam int S_DET = 3; // detected bit of rx_stat
  localparam int S_IDLE = 2; // idle bit of rx_stat
  localparam int S_EMPTY = 1; // empty bit of rx_stat
  localparam int S_OVF = 0; // overflow bit of rx_stat
  logic clk, sys_rst, tx_mode_wr, tx_bit_req, tx_bit_out; // clock, reset, tx side
  logic rx_bit_valid, rx_bit, rx_bit_ready, rx_code_rd, rx_ovf_clr, fault; // rx side
  fecw_code_wr_t code_wr; // code write strobes
  fecw_mode_t tx_mode; // mode to select
  logic [5:0] tx_code_first, tx_code_second, rx_code_fifo_out; // code outputs
  fecw_rx_stat_t rx_stat; // receive status
  int err_total = 0; // mismatches
  int n_tests = 0; // comparisons
  logic [5:0] ecode [4] = '{6'h34, 6'h11, 6'h22, 6'h3c}; // fifo order in overflow test

  fecw_top uut (.clk(clk), .sys_rst(sys_rst), .code_wr(code_wr), .tx_mode(tx_mode),
    .tx_mode_wr(tx_mode_wr), .tx_bit_req(tx_bit_req), .tx_bit_out(tx_bit_out),
    .tx_code_first(tx_code_first), .tx_code_second(tx_code_second),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_bit_ready(rx_bit_ready),
    .rx_code_rd(rx_code_rd), .rx_ovf_clr(rx_ovf_clr), .rx_code_fifo_out(rx_code_fifo_out),
    .rx_stat(rx_stat));
  fecw_line_model line_m (.clk(clk), .tx_bit_req(tx_bit_req), .tx_bit_out(tx_bit_out),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_bit_ready(rx_bit_ready), .fault(fault));

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // codeword: zero, code first bit (bit 0) to last, zero, eight ones
  function automatic logic [15:0] cw(input logic [5:0] c);
    return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hff};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // prints counts and verdict, ends the run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // loads both transmit codes back to back
  task automatic wr_codes(input logic [5:0] a, input logic [5:0] b);
    @(negedge clk) code_wr = '{wr_first: 1'b1, wr_second: 1'b0, code: a};
    @(negedge clk) code_wr = '{wr_first: 1'b0, wr_second: 1'b1, code: b};
    @(negedge clk) code_wr = '0;
    `CHK(tx_code_first, a)
    `CHK(tx_code_second, b)
  endtask

  // one-cycle mode write
  task automatic set_mode(input fecw_mode_t m);
    @(negedge clk);
    tx_mode = m;
    tx_mode_wr = 1'b1;
    @(negedge clk) tx_mode_wr = 1'b0;
  endtask

  // pulls n words and compares each
  task automatic expect_words(input logic [15:0] e, input int n);
    logic [15:0] w;
    repeat (n) begin
      line_m.get_word(w);
      `CHK(w, e)
    end
  endtask

  // sends one word n times
  task automatic send_n(input logic [15:0] w, input int n);
    repeat (n) line_m.send_word(w);
  endtask

  // waits, bounded, for one status bit to reach a level
  task automatic wait_stat(input int idx, input logic v);
    int k;
    k = 0;
    while (rx_stat[idx] !== v && k < 200) begin
      @(negedge clk);
      k++;
    end
    `CHK(rx_stat[idx], v)
    if (k == 200) conclude();
  endtask

  // one-cycle fifo read, compares the code a cycle later
  task automatic read_code(input logic [5:0] e);
    @(negedge clk) rx_code_rd = 1'b1;
    @(negedge clk) rx_code_rd = 1'b0;
    @(negedge clk);
    `CHK(rx_code_fifo_out, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    code_wr = '0;
    tx_mode = FECW_MODE_IDLE;
    tx_mode_wr = 1'b0;
    rx_code_rd = 1'b0;
    rx_ovf_clr = 1'b0;
    repeat (8) @(negedge clk);
    // values held in reset
    `CHK(tx_bit_out, 1'b1)
    `CHK(rx_stat, 4'h2)
    `CHK({tx_code_first, tx_code_second, rx_code_fifo_out}, 18'h0_0000)
    `CHK(rx_bit_ready, 1'b1)
    sys_rst = 1'b0;
    // transmit modes
    wr_codes(6'h05, 6'h2a);
    expect_words(16'hffff, 1);
    set_mode(FECW_MODE_SINGLE);
    expect_words(cw(6'h05), 10);
    expect_words(16'hffff, 1);
    set_mode(FECW_MODE_DUAL);
    expect_words(cw(6'h05), 10);
    expect_words(cw(6'h2a), 10);
    expect_words(16'hffff, 1);
    set_mode(FECW_MODE_CONT);
    expect_words(cw(6'h05), 12);
    set_mode(FECW_MODE_IDLE);
    expect_words(16'hffff, 2);
    $display("test transmit finished");
    // receive detection, idle and fifo
    send_n(16'hffff, 1);
    wait_stat(S_IDLE, 1'b1);
    send_n(cw(6'h0b), 3);
    wait_stat(S_DET, 1'b1);
    `CHK(rx_stat[S_IDLE], 1'b0)
    wait_stat(S_EMPTY, 1'b0);
    read_code(6'h0b);
    wait_stat(S_EMPTY, 1'b1);
    read_code(6'h0b);
    send_n(cw(6'h34), 2);
    wait_stat(S_DET, 1'b0);
    send_n(cw(6'h34), 1);
    wait_stat(S_DET, 1'b1);
    send_n(16'hffff, 1);
    wait_stat(S_IDLE, 1'b1);
    `CHK(rx_stat[S_DET], 1'b0)
    $display("test receive finished");
    // fill the code fifo past full
    for (int i = 1; i < 4; i++) begin
      send_n(cw(ecode[i]), 3);
    end
    `CHK(rx_stat[S_OVF], 1'b0)
    send_n(cw(6'h07), 3);
    wait_stat(S_OVF, 1'b1);
    for (int i = 0; i < 4; i++) begin
      read_code(ecode[i]);
    end
    wait_stat(S_EMPTY, 1'b1);
    read_code(6'h3c);
    @(negedge clk) rx_ovf_clr = 1'b1;
    @(negedge clk) rx_ovf_clr = 1'b0;
    wait_stat(S_OVF, 1'b0);
    `CHK(fault, 1'b0)
    $display("test fifo finished");
    conclude();
  end
endmodule
`default_nettype wire
